// ===== hdl/cap_id_pkg.sv
// Constants and carrier types for the capability revision and type register
// Functional notes
// - Bits 3:0 hold a read-only structure revision field.
// - The revision field always reads as 1h.
// - Later revisions keep the layout software-compatible; this revision is fixed at 1h.
// - Type bits 7:4: 0000b native endpoint, 0001b legacy endpoint.
// - Type reads 0100b for a root port of a root complex.
// - Type reads 0101b for switch upstream port, 0110b for downstream port.
// - Types 0111b, 1000b, 1001b, 1010b are bridges/integrated/collector; others reserved.
// - Port and bridge codes are reported only with the type 01h header.
package cap_id_pkg;
  localparam logic [7:0] CAP_REG_OFFSET = 8'h02;
  localparam int REV_LSB = 0;
  localparam int TYPE_LSB = 4;
  localparam logic [3:0] CAP_REVISION = 4'h1;
  localparam logic [15:0] RD_DATA_RESET = 16'h0000;
  localparam logic [7:0] HDR_TYPE_BRIDGE = 8'h01;

  localparam logic [3:0] TYPE_ENDPOINT = 4'h0;
  localparam logic [3:0] TYPE_LEGACY_EP = 4'h1;
  localparam logic [3:0] TYPE_ROOT_PORT = 4'h4;
  localparam logic [3:0] TYPE_SW_UP = 4'h5;
  localparam logic [3:0] TYPE_SW_DOWN = 4'h6;
  localparam logic [3:0] TYPE_BRIDGE_FWD = 4'h7;
  localparam logic [3:0] TYPE_BRIDGE_REV = 4'h8;
  localparam logic [3:0] TYPE_INTEGRATED_EP = 4'h9;
  localparam logic [3:0] TYPE_EVENT_COLL = 4'hA;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic [15:0] rd_data;
    logic rd_valid;
  } cap_state_t;
endpackage : cap_id_pkg

// ===== hdl/cap_id_reg.sv
// Read-only capability revision and type register on the configuration access path
module cap_id_reg #(
  parameter logic [3:0] DEV_TYPE = 4'h0,
  parameter logic [7:0] HDR_TYPE = 8'h00
) (
  // Clock, reset, enable
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // Configuration access request
  input wire cap_id_pkg::cfg_req_t CFG_REQ_IN,
  // Read answer
  output logic [15:0] RD_DATA_OUT,
  output logic RD_VALID_OUT
);
  import cap_id_pkg::*;

  cap_state_t state_reg;
  cap_state_t state_next;
  logic [3:0] eff_type;
  logic [15:0] cap_word;
  logic hdr_dep;
  logic hdr_ok;
  logic type_legal;
  logic hit;

  always_comb begin
    unique case (DEV_TYPE)
      TYPE_ENDPOINT,
      TYPE_LEGACY_EP,
      TYPE_ROOT_PORT,
      TYPE_SW_UP,
      TYPE_SW_DOWN,
      TYPE_BRIDGE_FWD,
      TYPE_BRIDGE_REV,
      TYPE_INTEGRATED_EP,
      TYPE_EVENT_COLL: type_legal = 1'b1;
      default: type_legal = 1'b0;
    endcase
  end

  // Header-dependent codes need the bridge header
  assign hdr_dep = DEV_TYPE inside {
    TYPE_ROOT_PORT,
    TYPE_SW_UP,
    TYPE_SW_DOWN,
    TYPE_BRIDGE_FWD,
    TYPE_BRIDGE_REV
  };
  assign hdr_ok = !hdr_dep || (HDR_TYPE == HDR_TYPE_BRIDGE);

  // Misconfigured type falls back to a native endpoint
  // Software then never sees a reserved or header-mismatched code
  always_comb begin
    if (type_legal && hdr_ok) begin
      eff_type = DEV_TYPE;
    end else begin
      eff_type = TYPE_ENDPOINT;
    end
  end

  // Hardwired revision; upper bits are outside this block and read zero
  always_comb begin
    cap_word = RD_DATA_RESET;
    cap_word[REV_LSB +: 4] = CAP_REVISION;
    cap_word[TYPE_LSB +: 4] = eff_type;
  end

  assign hit = CFG_REQ_IN.addr == CAP_REG_OFFSET;

  always_comb begin
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    // Writes are accepted silently and store nothing
    if (CFG_REQ_IN.rd) begin
      state_next.rd_valid = 1'b1;
      // Unmapped offsets answer zero so a probe never hangs
      if (hit) begin
        state_next.rd_data = cap_word;
      end else begin
        state_next.rd_data = RD_DATA_RESET;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      state_reg <= '{rd_data: RD_DATA_RESET, rd_valid: 1'b0};
    end else if (CE_IN) begin
      state_reg <= state_next;
    end
  end

  assign RD_DATA_OUT = state_reg.rd_data;
  assign RD_VALID_OUT = state_reg.rd_valid;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // Answer word checks

  a_rev_value: assert property (
    CE_IN && CFG_REQ_IN.rd && hit |=> RD_VALID_OUT && RD_DATA_OUT[3:0] == 4'h1)
    else $error("revision field not 1h");

  a_type_value: assert property (
    CE_IN && CFG_REQ_IN.rd && hit |=> RD_DATA_OUT[7:4] == eff_type)
    else $error("type field wrong");

  a_upper_zero: assert property (
    CE_IN && CFG_REQ_IN.rd |=> RD_DATA_OUT[15:8] == 8'h00)
    else $error("upper bits not zero");

  a_write_ignored: assert property (
    CE_IN && CFG_REQ_IN.wr && !CFG_REQ_IN.rd ##1 CE_IN && CFG_REQ_IN.rd && hit
    |=> RD_DATA_OUT[7:0] == {eff_type, CAP_REVISION})
    else $error("write altered read value");

  a_unmapped_zero: assert property (
    CE_IN && CFG_REQ_IN.rd && !hit |=> RD_VALID_OUT && RD_DATA_OUT == 16'h0000)
    else $error("unmapped read not zero");

  a_freeze_hold: assert property (
    !CE_IN |=> $stable(RD_VALID_OUT) && $stable(RD_DATA_OUT))
    else $error("state moved while disabled");

  a_type_legal: assert property (
    RD_VALID_OUT |-> !(RD_DATA_OUT[7:4] inside {4'h2, 4'h3, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF}))
    else $error("reserved type reported");

  a_hdr_dep: assert property (
    RD_VALID_OUT && RD_DATA_OUT[7:4] inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h8}
    |-> HDR_TYPE == 8'h01)
    else $error("port type without bridge header");

  a_valid_pulse: assert property (
    CE_IN && !CFG_REQ_IN.rd |=> !RD_VALID_OUT)
    else $error("answer without read");

  a_rev_const: assert property (
    RD_VALID_OUT && RD_DATA_OUT != 16'h0000 |-> RD_DATA_OUT[3:0] == CAP_REVISION)
    else $error("nonzero answer with wrong revision");

  a_type_range: assert property (
    RD_VALID_OUT |-> RD_DATA_OUT[7:4] <= TYPE_EVENT_COLL)
    else $error("type above defined range");

  // Type selection checks

  a_eff_fallback: assert property (
    !type_legal |-> eff_type == TYPE_ENDPOINT)
    else $error("reserved type not replaced");

  a_hdr_fallback: assert property (
    !hdr_ok |-> eff_type == TYPE_ENDPOINT)
    else $error("header mismatch not replaced");

  a_type_keep: assert property (
    type_legal && hdr_ok |-> eff_type == DEV_TYPE)
    else $error("legal type not reported");

  // Handshake checks

  a_reset_clear: assert property (
    disable iff (1'b0) !RST_N_IN |=> !RD_VALID_OUT && RD_DATA_OUT == RD_DATA_RESET)
    else $error("reset did not clear answer");

  a_rdwr_read: assert property (
    CE_IN && CFG_REQ_IN.rd && CFG_REQ_IN.wr && hit
    |=> RD_VALID_OUT && RD_DATA_OUT[3:0] == CAP_REVISION)
    else $error("combined access not read");

  a_write_no_answer: assert property (
    CE_IN && CFG_REQ_IN.wr && !CFG_REQ_IN.rd |=> !RD_VALID_OUT)
    else $error("write produced an answer");

  a_hold_data: assert property (
    CE_IN && !CFG_REQ_IN.rd |=> $stable(RD_DATA_OUT))
    else $error("data moved without read");

  a_miss_valid: assert property (
    CE_IN && CFG_REQ_IN.rd && !hit |=> RD_VALID_OUT && RD_DATA_OUT[3:0] == 4'h0)
    else $error("unmapped read unanswered");

  a_back_to_back: assert property (
    CE_IN && CFG_REQ_IN.rd ##1 CE_IN && CFG_REQ_IN.rd |=> RD_VALID_OUT)
    else $error("second read unanswered");

  a_stall_no_answer: assert property (
    !CE_IN && !RD_VALID_OUT |=> !RD_VALID_OUT)
    else $error("answer while disabled");

  // Main scenarios
  c_hit_read: cover property (CE_IN && CFG_REQ_IN.rd && hit);
  c_miss_read: cover property (CE_IN && CFG_REQ_IN.rd && !hit);
  c_write: cover property (CE_IN && CFG_REQ_IN.wr && hit);
  c_stall: cover property (!CE_IN && CFG_REQ_IN.rd);
  c_combo: cover property (CE_IN && CFG_REQ_IN.rd && CFG_REQ_IN.wr && hit);
endmodule : cap_id_reg

// ===== testbench/cfg_sw_model.sv
// Configuration software model issuing accesses to the capability register
module cfg_sw_model (
  input wire logic clk_in,
  output cap_id_pkg::cfg_req_t req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import cap_id_pkg::*;
  initial req_out = '0;
  // Held across one sampling edge; wdata all ones so an ignored write would show
  task automatic access(input logic rd, input logic wr, input logic [7:0] addr);
    @(posedge clk_in);
    #1 req_out = '{rd, wr, addr, 16'hFFFF};
    @(posedge clk_in);
    #1 req_out = '0;
  endtask : access
endmodule : cfg_sw_model

// ===== testbench/cap_id_reg_tb_top.sv
// Self-checking bench for the capability revision and type register
module cap_id_reg_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cap_id_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  cfg_req_t req;
  logic [15:0] d0, d1;
  logic v0, v1;
  int failures = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  cfg_sw_model SW (.clk_in(clk), .req_out(req));
  cap_id_reg #(.DEV_TYPE(TYPE_ROOT_PORT), .HDR_TYPE(HDR_TYPE_BRIDGE)) DUT (.REF_CLK_IN(clk),
    .RST_N_IN(rst_n), .CE_IN(ce), .CFG_REQ_IN(req), .RD_DATA_OUT(d0), .RD_VALID_OUT(v0));
  // Switch port code without the bridge header must fall back to endpoint
  cap_id_reg #(.DEV_TYPE(TYPE_SW_UP)) DUT_NOHDR (.REF_CLK_IN(clk),
    .RST_N_IN(rst_n), .CE_IN(ce), .CFG_REQ_IN(req), .RD_DATA_OUT(d1), .RD_VALID_OUT(v1));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic read_cap();
    SW.access(1'b1, 1'b0, CAP_REG_OFFSET);
    check("read valid", {15'h0000, v0}, 16'h0001);
    check("root port word", d0, {8'h00, TYPE_ROOT_PORT, CAP_REVISION});
    check("revision field", {12'h000, d0[3:0]}, 16'h0001);
    check("fallback word", d1, {8'h00, TYPE_ENDPOINT, CAP_REVISION});
  endtask : read_cap
  task automatic write_cap();
    SW.access(1'b0, 1'b1, CAP_REG_OFFSET);
    check("write valid", {15'h0000, v0}, 16'h0000);
    check("word after write", d0, {8'h00, TYPE_ROOT_PORT, CAP_REVISION});
  endtask : write_cap
  task automatic miss_and_combo();
    SW.access(1'b1, 1'b0, 8'h00);
    check("miss valid", {15'h0000, v0}, 16'h0001);
    check("miss word", d0, RD_DATA_RESET);
    SW.access(1'b1, 1'b1, CAP_REG_OFFSET);
    check("combo word", d0, {8'h00, TYPE_ROOT_PORT, CAP_REVISION});
    check("fallback valid", {15'h0000, v1}, 16'h0001);
  endtask : miss_and_combo
  task automatic stall_read();
    @(posedge clk);
    #1 ce = 1'b0;
    SW.access(1'b1, 1'b0, 8'h00);
    check("stall valid", {15'h0000, v0}, 16'h0000);
    check("stall word", d0, {8'h00, TYPE_ROOT_PORT, CAP_REVISION});
    ce = 1'b1;
  endtask : stall_read
  task automatic reset_mid();
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check("reset valid", {15'h0000, v0}, 16'h0000);
    check("reset word", d0, RD_DATA_RESET);
    read_cap();
  endtask : reset_mid
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    read_cap();
    write_cap();
    miss_and_combo();
    stall_read();
    reset_mid();
    conclude();
  end
  // Whole run is about 20 cycles; this leaves wide margin
  initial begin
    #2000;
    failures++;
    conclude();
  end
endmodule : cap_id_reg_tb_top
